// >>> pkg/pseq_pkg.sv
// register map, field positions and carrier types of the pattern sequencer
package pseq_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] REG_MEM_ADDR  = 8'h10;
    localparam logic [7:0] REG_MEM_DATA  = 8'h14;
    localparam logic [7:0] REG_DESC_SEL  = 8'h18;
    localparam logic [7:0] REG_DESC_A    = 8'h1c;
    localparam logic [7:0] REG_DESC_B    = 8'h20;
    localparam logic [7:0] REG_OUTER     = 8'h24;
    localparam logic [7:0] REG_LAST      = 8'h28;
    localparam logic [7:0] REG_MATCH_SEL = 8'h2c;
    localparam logic [7:0] REG_MATCH_VAL = 8'h30;
    localparam logic [7:0] REG_MATCH_MSK = 8'h34;
    localparam logic [7:0] REG_MATCH_BYT = 8'h38;
    localparam logic [7:0] REG_SKIP_VAL  = 8'h3c;
    localparam logic [7:0] REG_SKIP_MSK  = 8'h40;
    // control field positions
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_PROTO  = 1;
    localparam int CTRL_EN_SW  = 2;
    localparam int CTRL_EN_EXT = 3;
    localparam int CTRL_EN_HIT = 4;
    localparam int CTRL_FILT   = 5;
    localparam int CTRL_SW_ADV = 8;
    localparam int CTRL_W      = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // interrupt bits
    localparam int IRQ_ADV  = 0;
    localparam int IRQ_HIT  = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_ERR  = 3;
    localparam int IRQ_W    = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // segment, loop and matcher limits
    localparam int WORD_BITS     = 32;
    localparam int SEG_MIN_BITS  = 128;
    localparam int SEG_MIN_WORDS = SEG_MIN_BITS / WORD_BITS + 1;
    localparam int LOOP_MAX      = 1000000;
    localparam int LOOP_W        = 20;
    localparam int MATCH_BITS    = 128;
    localparam int N_ELEM        = 16;
    localparam int N_BIT_ELEM    = 4;
    // protocol headers and scrambler seed
    localparam logic [1:0]  HDR_DATA   = 2'h1;
    localparam logic [1:0]  HDR_CTL    = 2'h2;
    localparam logic [31:0] LFSR_SEED  = 32'h0000_0001;
    // one segment descriptor
    typedef struct packed {
        logic              wt;
        logic              ctl;
        logic [LOOP_W-1:0] reps;
        logic [15:0]       len;
        logic [15:0]       start;
    } pseq_desc_type;
    // sequencer states
    typedef enum logic [2:0] {
        PSEQ_IDLE = 3'b001,
        PSEQ_PLAY = 3'b010,
        PSEQ_HALT = 3'b100
    } pseq_state_type;
endpackage

// >>> src/pseq_top.sv
// pattern memory sequencer with transmit processing and receive matchers
//
// Overview of operation
// - two loop levels, up to a million repeats
// - segments above 128 bits, addressed indirectly
// - advance on software, external pin, or match
// - bit mode sends memory words untouched
// - protocol mode adds header, scrambling, balancing
// - both modes share loops and advance triggers
// - scrambler and disparity persist across state changes
// - four masked 128-bit raw matchers in bit mode
// - a matcher hit can advance the sequencer
// - sixteen decoded-content match elements in protocol mode
// - block payload compare with bit and byte masks
// - up to sixteen decoded bytes matched, masked
// - skip words dropped from the decoded stream
// - error stream selectable raw or filtered
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module pseq_top #(
    parameter int MEM_AW = 10,   // pattern memory address bits
    parameter int ST_W   = 4     // sequencer state index bits
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        ext_adv,
    output logic      [31:0] tx_data,
    output logic             tx_valid,
    output logic      [1:0]  tx_hdr,
    output logic             tx_inv,
    input  wire logic [31:0] rx_data,
    input  wire logic [31:0] rx_dec,
    input  wire logic        rx_valid,
    output logic      [31:0] chk_data,
    output logic             chk_valid
);
    localparam int NST = 1 << ST_W;

    // refuse sizes the descriptor fields cannot address
    if (MEM_AW < 4 || MEM_AW > 16 || ST_W < 1 || ST_W > 8) begin : g_bad
        $error("pseq_top: MEM_AW or ST_W out of range");
    end

    logic [5:0]              ctrl;          // control bits
    logic [3:0]              irq_stat;      // sticky events
    logic [3:0]              irq_mask;      // 1 lets an event through
    logic [MEM_AW-1:0]       mem_addr;      // indirect write pointer
    logic [31:0]             mem [1<<MEM_AW];
    logic [ST_W-1:0]         desc_sel;
    pseq_pkg::pseq_desc_type desc [NST];
    logic [pseq_pkg::LOOP_W-1:0] outer;     // outer loop count, 0 runs forever
    logic [ST_W-1:0]         last_idx;      // last state of the chain
    logic [5:0]              msel;          // element and word select
    logic [127:0]            mval [16];
    logic [127:0]            mmsk [16];
    logic [15:0]             mbyt [16];     // 1 ignores that byte
    logic [31:0]             skip_val;
    logic [31:0]             skip_msk;

    // write strobes
    logic wr_ctrl;
    logic sw_adv;
    assign wr_ctrl = reg_wr && reg_addr == pseq_pkg::REG_CTRL;
    assign sw_adv  = wr_ctrl && reg_wdata[pseq_pkg::CTRL_SW_ADV];

    // control register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl <= pseq_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata[5:0];
        end
    end

    // pattern memory, written through an auto-incrementing pointer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_addr <= '0;
        end else if (reg_wr && reg_addr == pseq_pkg::REG_MEM_ADDR) begin
            mem_addr <= reg_wdata[MEM_AW-1:0];
        end else if (reg_wr && reg_addr == pseq_pkg::REG_MEM_DATA) begin
            mem_addr <= mem_addr + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reg_wr && reg_addr == pseq_pkg::REG_MEM_DATA) begin
            mem[mem_addr] <= reg_wdata;
        end
    end

    // descriptor table and chain limits; indirect segment addressing
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            desc_sel <= '0;
            outer    <= '0;
            last_idx <= '0;
            for (int i = 0; i < NST; i++) begin
                desc[i] <= '0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                pseq_pkg::REG_DESC_SEL: desc_sel <= reg_wdata[ST_W-1:0];
                pseq_pkg::REG_DESC_A: begin
                    desc[desc_sel].start <= reg_wdata[15:0];
                    desc[desc_sel].len   <= reg_wdata[31:16];
                end
                pseq_pkg::REG_DESC_B: begin
                    desc[desc_sel].reps <= reg_wdata[pseq_pkg::LOOP_W-1:0];
                    desc[desc_sel].ctl  <= reg_wdata[30];
                    desc[desc_sel].wt   <= reg_wdata[31];
                end
                pseq_pkg::REG_OUTER: outer    <= reg_wdata[pseq_pkg::LOOP_W-1:0];
                pseq_pkg::REG_LAST:  last_idx <= reg_wdata[ST_W-1:0];
                default: ;
            endcase
        end
    end

    // matcher patterns and skip filter; zero masks keep elements quiet
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            msel     <= '0;
            skip_val <= '0;
            skip_msk <= '0;
            for (int i = 0; i < 16; i++) begin
                mval[i] <= '0;
                mmsk[i] <= '0;
                mbyt[i] <= '0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                pseq_pkg::REG_MATCH_SEL: msel <= reg_wdata[5:0];
                pseq_pkg::REG_MATCH_VAL: mval[msel[3:0]][msel[5:4]*32 +: 32] <= reg_wdata;
                pseq_pkg::REG_MATCH_MSK: mmsk[msel[3:0]][msel[5:4]*32 +: 32] <= reg_wdata;
                pseq_pkg::REG_MATCH_BYT: mbyt[msel[3:0]] <= reg_wdata[15:0];
                pseq_pkg::REG_SKIP_VAL:  skip_val <= reg_wdata;
                pseq_pkg::REG_SKIP_MSK:  skip_msk <= reg_wdata;
                default: ;
            endcase
        end
    end

    // receive side: raw and filtered histories, four words each
    logic [127:0] raw_h;
    logic [127:0] dec_h;
    logic         raw_upd;
    logic         dec_upd;
    logic         skip;
    assign skip = skip_msk != '0 && ((rx_dec ^ skip_val) & skip_msk) == '0;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            raw_h   <= '0;
            dec_h   <= '0;
            raw_upd <= 1'b0;
            dec_upd <= 1'b0;
        end else begin
            raw_upd <= rx_valid;
            dec_upd <= rx_valid && !skip;
            if (rx_valid) begin
                raw_h <= {raw_h[95:0], rx_data};
            end
            if (rx_valid && !skip) begin
                dec_h <= {dec_h[95:0], rx_dec};
            end
        end
    end

    // byte ignore mask widened to bit lanes
    function automatic logic [127:0] pseq_bexp(input logic [15:0] m);
        logic [127:0] r;
        r = '0;
        for (int b = 0; b < 16; b++) begin
            r[b*8 +: 8] = {8{~m[b]}};
        end
        return r;
    endfunction

    // one comparator per element; matches are word aligned only
    logic [15:0] cmp;
    for (genvar e = 0; e < pseq_pkg::N_ELEM; e++) begin : g_elem
        logic [127:0] src;
        logic         upd;
        assign src = ctrl[pseq_pkg::CTRL_PROTO] ? dec_h : raw_h;
        assign upd = ctrl[pseq_pkg::CTRL_PROTO] ? dec_upd
                   : (raw_upd && e < pseq_pkg::N_BIT_ELEM);
        // bit mask and byte mask both apply
        assign cmp[e] = upd && mmsk[e] != '0
                     && ((src ^ mval[e]) & mmsk[e] & pseq_bexp(mbyt[e])) == '0;
    end

    logic [15:0] hit_q;    // one pulse per matching update
    logic        hit_any;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hit_q <= '0;
        end else begin
            hit_q <= cmp;
        end
    end
    assign hit_any = |hit_q;

    // external advance pin, two-stage synchroniser then edge detect
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_adv;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // error counting stream, raw or filtered
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            chk_data  <= '0;
            chk_valid <= 1'b0;
        end else if (ctrl[pseq_pkg::CTRL_FILT]) begin
            chk_data  <= rx_dec;
            chk_valid <= rx_valid && !skip;
        end else begin
            chk_data  <= rx_data;
            chk_valid <= rx_valid;
        end
    end

    // sequencer state
    pseq_pkg::pseq_state_type fsm;
    logic [ST_W-1:0]          cur;
    logic [MEM_AW-1:0]        rd_ptr;
    logic [15:0]              words_left;
    logic [pseq_pkg::LOOP_W-1:0] reps_left;
    logic [pseq_pkg::LOOP_W-1:0] outer_left;
    logic                     pend;      // advance request waiting

    pseq_pkg::pseq_desc_type cur_d;
    pseq_pkg::pseq_desc_type d_ld;
    logic trig;
    logic seg_end;
    logic adv_now;
    logic finish;
    logic load_now;
    logic short_ld;
    logic take;
    always_comb begin
        cur_d   = desc[cur];
        seg_end = fsm == pseq_pkg::PSEQ_PLAY && words_left == 16'h0001;
        adv_now = pend || (!cur_d.wt && reps_left <= 1);
        finish  = cur == last_idx && outer_left == 1;
        take    = seg_end && pend && ctrl[pseq_pkg::CTRL_RUN];
        // same triggers whichever mode is selected
        trig = (sw_adv && ctrl[pseq_pkg::CTRL_EN_SW])
            || (ext_sync && !ext_prev && ctrl[pseq_pkg::CTRL_EN_EXT])
            || (hit_any && ctrl[pseq_pkg::CTRL_EN_HIT]);
        d_ld = (fsm == pseq_pkg::PSEQ_IDLE || cur == last_idx) ? desc[0]
             : desc[cur + 1'b1];
        load_now = ctrl[pseq_pkg::CTRL_RUN]
                && (fsm == pseq_pkg::PSEQ_IDLE || (seg_end && adv_now && !finish));
        short_ld = d_ld.len < 16'(pseq_pkg::SEG_MIN_WORDS);
    end

    // pending advance; a new trigger beats the clear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pend <= 1'b0;
        end else if (trig) begin
            pend <= 1'b1;
        end else if (take || fsm != pseq_pkg::PSEQ_PLAY) begin
            pend <= 1'b0;
        end
    end

    // segment walk, inner repeats and outer chain loop
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fsm        <= pseq_pkg::PSEQ_IDLE;
            cur        <= '0;
            rd_ptr     <= '0;
            words_left <= '0;
            reps_left  <= '0;
            outer_left <= '0;
        end else if (!ctrl[pseq_pkg::CTRL_RUN]) begin
            fsm <= pseq_pkg::PSEQ_IDLE;
        end else begin
            case (fsm)
                pseq_pkg::PSEQ_IDLE: begin
                    outer_left <= outer;
                end
                pseq_pkg::PSEQ_PLAY: begin
                    if (seg_end && adv_now && finish) begin
                        fsm <= pseq_pkg::PSEQ_HALT;
                    end else if (seg_end && adv_now) begin
                        // leaving the last state closes one outer pass
                        if (cur == last_idx && outer_left != '0) begin
                            outer_left <= outer_left - 1'b1;
                        end
                    end else if (seg_end) begin
                        // replay the segment; wait states loop freely
                        rd_ptr     <= cur_d.start[MEM_AW-1:0];
                        words_left <= cur_d.len;
                        if (!cur_d.wt) begin
                            reps_left <= reps_left - 1'b1;
                        end
                    end else begin
                        rd_ptr     <= rd_ptr + 1'b1;
                        words_left <= words_left - 1'b1;
                    end
                end
                pseq_pkg::PSEQ_HALT: ;
                default: fsm <= pseq_pkg::PSEQ_IDLE;
            endcase
            if (load_now) begin
                cur        <= (fsm == pseq_pkg::PSEQ_IDLE || cur == last_idx) ? '0
                            : cur + 1'b1;
                rd_ptr     <= d_ld.start[MEM_AW-1:0];
                words_left <= d_ld.len;
                reps_left  <= d_ld.reps;
                fsm        <= short_ld ? pseq_pkg::PSEQ_HALT : pseq_pkg::PSEQ_PLAY;
            end
        end
    end

    // transmit stage one: fetch the word
    logic [31:0] mem_q;
    logic        v1;
    logic        ctl1;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_q <= '0;
            v1    <= 1'b0;
            ctl1  <= 1'b0;
        end else begin
            mem_q <= mem[rd_ptr];
            v1    <= fsm == pseq_pkg::PSEQ_PLAY && ctrl[pseq_pkg::CTRL_RUN];
            ctl1  <= cur_d.ctl;
        end
    end

    // scrambler stepped 32 bits per word, then disparity balance
    logic        [31:0] lfsr;
    logic        [31:0] next_lfsr;
    logic        [31:0] scr;
    logic        [5:0]  ones;
    logic signed [7:0]  disp;
    logic signed [7:0]  next_disp;
    logic signed [7:0]  dw;
    logic               inv;
    always_comb begin
        next_lfsr = lfsr;
        scr       = mem_q;
        ones      = '0;
        for (int i = 0; i < 32; i++) begin
            scr[31-i] = mem_q[31-i] ^ next_lfsr[31];
            next_lfsr = {next_lfsr[30:0],
                         next_lfsr[31] ^ next_lfsr[21] ^ next_lfsr[1] ^ next_lfsr[0]};
        end
        for (int i = 0; i < 32; i++) begin
            ones = ones + 6'(scr[i]);
        end
        dw        = $signed({1'b0, ones, 1'b0}) - 8'sd32;
        inv       = (disp > 0 && dw > 0) || (disp < 0 && dw < 0);
        next_disp = inv ? disp - dw : disp + dw;
    end

    // state survives segment and state changes, reset only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lfsr <= pseq_pkg::LFSR_SEED;
            disp <= '0;
        end else if (v1 && ctrl[pseq_pkg::CTRL_PROTO]) begin
            lfsr <= next_lfsr;
            disp <= next_disp;
        end
    end

    // transmit stage two: raw or processed word
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_data  <= '0;
            tx_valid <= 1'b0;
            tx_hdr   <= '0;
            tx_inv   <= 1'b0;
        end else begin
            tx_valid <= v1;
            if (!ctrl[pseq_pkg::CTRL_PROTO]) begin
                tx_data <= mem_q;
                tx_hdr  <= '0;
                tx_inv  <= 1'b0;
            end else begin
                tx_data <= inv ? ~scr : scr;
                tx_hdr  <= ctl1 ? pseq_pkg::HDR_CTL : pseq_pkg::HDR_DATA;
                tx_inv  <= inv;
            end
        end
    end

    // sticky events, write one to clear, set beats clear
    logic [3:0] ev;
    logic [3:0] clr;
    assign ev  = {load_now && short_ld, seg_end && adv_now && finish, hit_any, take};
    assign clr = (reg_wr && reg_addr == pseq_pkg::REG_IRQ_STAT) ? reg_wdata[3:0] : 4'h0;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_stat <= pseq_pkg::IRQ_RESET;
            irq_mask <= pseq_pkg::IRQ_RESET;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~clr) | ev;
            irq      <= |(irq_stat & irq_mask);
            if (reg_wr && reg_addr == pseq_pkg::REG_IRQ_MASK) begin
                irq_mask <= reg_wdata[3:0];
            end
        end
    end

    // read data for one cycle; write-only and unmapped read zero
    always_ff @(posedge sys_clk) begin
        if (!resetn || !reg_rd) begin
            reg_rdata <= '0;
        end else begin
            case (reg_addr)
                pseq_pkg::REG_CTRL:     reg_rdata <= {26'h0, ctrl};
                pseq_pkg::REG_STATUS:   reg_rdata <= {hit_q, 4'h0, pend, fsm, 8'(cur)};
                pseq_pkg::REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat};
                pseq_pkg::REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask};
                default:                reg_rdata <= '0;
            endcase
        end
    end

    property p_reps_dec;
        @(posedge sys_clk) disable iff (!resetn)
        seg_end && !adv_now && !cur_d.wt && ctrl[0] |=> reps_left == $past(reps_left) - 1;
    endproperty
    a_reps_dec: assert property (p_reps_dec) else $error("repeat count not stepped");

    property p_seg_min;
        @(posedge sys_clk) disable iff (!resetn)
        fsm == pseq_pkg::PSEQ_PLAY |-> cur_d.len >= 16'(pseq_pkg::SEG_MIN_WORDS);
    endproperty
    a_seg_min: assert property (p_seg_min) else $error("short segment played");

    property p_pend_set;
        @(posedge sys_clk) disable iff (!resetn)
        trig |=> pend;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("trigger lost");

    property p_bit_raw;
        @(posedge sys_clk) disable iff (!resetn)
        tx_valid && !$past(ctrl[1]) |-> tx_data == $past(mem_q) && tx_hdr == 2'h0;
    endproperty
    a_bit_raw: assert property (p_bit_raw) else $error("bit mode word altered");

    property p_proto_hdr;
        @(posedge sys_clk) disable iff (!resetn)
        tx_valid && $past(ctrl[1]) |-> tx_hdr != 2'h0 && tx_inv == $past(inv);
    endproperty
    a_proto_hdr: assert property (p_proto_hdr) else $error("protocol word unframed");

    property p_lfsr_carry;
        @(posedge sys_clk) disable iff (!resetn)
        $past(load_now) && $past(v1 && ctrl[1]) |-> lfsr == $past(next_lfsr);
    endproperty
    a_lfsr_carry: assert property (p_lfsr_carry) else $error("scrambler reset");

    property p_bit_elems;
        @(posedge sys_clk) disable iff (!resetn)
        !$past(ctrl[1]) |-> hit_q[15:4] == 12'h000;
    endproperty
    a_bit_elems: assert property (p_bit_elems) else $error("extra bit matcher");

    property p_dec_hit;
        @(posedge sys_clk) disable iff (!resetn)
        $past(ctrl[1]) && hit_any |-> $past(dec_upd);
    endproperty
    a_dec_hit: assert property (p_dec_hit) else $error("hit without decoded word");

    property p_skip_drop;
        @(posedge sys_clk) disable iff (!resetn)
        rx_valid && skip |=> $stable(dec_h) && !dec_upd;
    endproperty
    a_skip_drop: assert property (p_skip_drop) else $error("skip word kept");

    property p_chk_raw;
        @(posedge sys_clk) disable iff (!resetn)
        $past(rx_valid) && !$past(ctrl[5]) |-> chk_valid && chk_data == $past(rx_data);
    endproperty
    a_chk_raw: assert property (p_chk_raw) else $error("raw check stream wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!resetn)
        fsm == pseq_pkg::PSEQ_PLAY && pend && !seg_end && ctrl[0] |=> $stable(cur);
    endproperty
    a_hold: assert property (p_hold) else $error("segment cut short");
endmodule // pseq_top

// >>> tb/pseq_rx_model.sv
// loopback model of the receiver under test
`timescale 1ns/1ps
module pseq_rx_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] tx_data,
    input  wire logic        tx_valid,
    output logic      [31:0] rx_data = 32'h0,
    output logic      [31:0] rx_dec = 32'h0,
    output logic             rx_valid = 1'b0
);
    // echo one cycle late; idle lines flip so a stale word never looks valid
    always_ff @(posedge sys_clk) begin
        rx_valid <= tx_valid;
        rx_data  <= tx_valid ? tx_data : ~rx_data;
        rx_dec   <= tx_valid ? tx_data : ~rx_dec;
    end
endmodule // pseq_rx_model

// >>> tb/pattern_sequencer_with_match_advance_tb.sv
// self-checking bench of the sequencer, looped back through the receiver
`timescale 1ns/1ps
module pattern_sequencer_with_match_advance_tb;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ext_adv = 1'b0;
    logic [31:0] reg_rdata, tx_data, rx_data, rx_dec, chk_data, v;
    logic [1:0]  tx_hdr;
    logic        irq, tx_valid, tx_inv, rx_valid, chk_valid;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    pseq_top dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .ext_adv(ext_adv), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_hdr(tx_hdr), .tx_inv(tx_inv), .rx_data(rx_data), .rx_dec(rx_dec),
        .rx_valid(rx_valid), .chk_data(chk_data), .chk_valid(chk_valid));
    pseq_rx_model far (.sys_clk(sys_clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_data(rx_data), .rx_dec(rx_dec), .rx_valid(rx_valid));
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one-cycle strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // descriptor: words from address 0, one repeat
    task automatic seg(input logic [3:0] i, input logic [15:0] len, input logic wt);
        wr(pseq_pkg::REG_DESC_SEL, {28'h0, i});
        wr(pseq_pkg::REG_DESC_A, {len, 16'h0000});
        wr(pseq_pkg::REG_DESC_B, {wt, 31'h1});
    endtask
    // bit mode sends memory words untouched, then stops with done
    task automatic s_play();
        seg(4'h0, 16'h5, 1'b0);
        wr(pseq_pkg::REG_LAST, 32'h0);
        wr(pseq_pkg::REG_OUTER, 32'h1);
        wr(pseq_pkg::REG_CTRL, 32'h1);
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            if (tx_valid === 1'b1) break;
        end
        for (int i = 0; i < 5; i++) begin
            chk(tx_data, 32'ha5a5_0000 + i);
            chk({29'h0, tx_inv, tx_hdr}, 32'h0);
            @(posedge sys_clk);
            #1;
        end
        repeat (6) @(posedge sys_clk);
        rd(pseq_pkg::REG_IRQ_STAT);
        chk(v & 32'h4, 32'h4);
        wr(pseq_pkg::REG_IRQ_MASK, 32'h4);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(pseq_pkg::REG_IRQ_STAT, 32'h4);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(pseq_pkg::REG_CTRL, 32'h0);
    endtask
    // a segment of only 128 bits is refused
    task automatic s_short();
        seg(4'h0, 16'h4, 1'b0);
        wr(pseq_pkg::REG_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk);
        rd(pseq_pkg::REG_IRQ_STAT);
        chk(v & 32'h8, 32'h8);
        rd(pseq_pkg::REG_STATUS);
        chk(v & 32'h700, 32'h400);
        wr(pseq_pkg::REG_IRQ_STAT, 32'hffff_ffff);
        wr(pseq_pkg::REG_CTRL, 32'h0);
    endtask
    // looped-back word hits matcher 0 and frees a waiting segment
    task automatic s_match();
        seg(4'h0, 16'h5, 1'b1);
        seg(4'h1, 16'h5, 1'b0);
        wr(pseq_pkg::REG_LAST, 32'h1);
        wr(pseq_pkg::REG_MATCH_SEL, 32'h0);
        wr(pseq_pkg::REG_MATCH_VAL, 32'ha5a5_0002);
        wr(pseq_pkg::REG_MATCH_MSK, 32'hffff_ffff);
        wr(pseq_pkg::REG_CTRL, 32'h11);
        repeat (40) @(posedge sys_clk);
        rd(pseq_pkg::REG_IRQ_STAT);
        chk(v & 32'h7, 32'h7);
    endtask
    // wait segment holds till trigger
    task automatic s_adv(input logic [31:0] c, input logic pin);
        wr(pseq_pkg::REG_CTRL, 32'h0);
        wr(pseq_pkg::REG_IRQ_STAT, 32'hf);
        wr(pseq_pkg::REG_CTRL, c);
        repeat (30) @(posedge sys_clk);
        rd(pseq_pkg::REG_IRQ_STAT);
        chk(v & 32'h5, 32'h0);
        if (pin) ext_adv <= 1'b1;
        else wr(pseq_pkg::REG_CTRL, c | 32'h100);
        repeat (30) @(posedge sys_clk);
        ext_adv <= 1'b0;
        rd(pseq_pkg::REG_IRQ_STAT);
        chk(v & 32'h5, 32'h5);
    endtask
    // count check and framed words
    task automatic s_filt(input logic [31:0] c, input int nv, nh);
        int n = 0, h = 0;
        wr(pseq_pkg::REG_CTRL, c);
        repeat (30) begin
            @(posedge sys_clk);
            #1;
            n += (chk_valid === 1'b1);
            h += (tx_valid === 1'b1 && tx_hdr === pseq_pkg::HDR_DATA);
        end
        chk(n, nv);
        chk(h, nh);
        wr(pseq_pkg::REG_CTRL, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(pseq_pkg::REG_STATUS);
        chk(v, 32'h0000_0100);
        rd(8'hfc);
        chk(v, 32'h0);
        wr(pseq_pkg::REG_MEM_ADDR, 32'h0);
        for (int i = 0; i < 5; i++) wr(pseq_pkg::REG_MEM_DATA, 32'ha5a5_0000 + i);
        s_play();
        s_short();
        s_match();
        s_adv(32'h09, 1'b1);
        s_adv(32'h05, 1'b0);
        wr(pseq_pkg::REG_CTRL, 32'h0);
        seg(4'h0, 16'h5, 1'b0);
        wr(pseq_pkg::REG_DESC_B, 32'h2);
        wr(pseq_pkg::REG_LAST, 32'h0);
        wr(pseq_pkg::REG_SKIP_VAL, 32'ha5a5_0001);
        wr(pseq_pkg::REG_SKIP_MSK, 32'hffff_ffff);
        s_filt(32'h01, 10, 0);
        s_filt(32'h21, 8, 0);
        s_filt(32'h03, 10, 10);
        close_out();
    end
endmodule // pattern_sequencer_with_match_advance_tb
